/* core/mcp_regs.sv */
// Notes on behaviour
// - Two config bits hold off sampling, bit trials.
// - Reset leaves delays and filters enabled.
// - Sampling hold-off bit one: fixed sampling instant.
// - Hold-off over one microsecond aborts conversion.
// - Bit trials pause during bus activity.
// - Filter enabled rejects glitches under 50 ns.
// - Autocycle, differential, pseudo-differential pair selects.
// - Bits seven to four double input range.
// - Bit zero sets alert output polarity.
// - Pin field selects none, busy, alert.
// - Writing 11 clears pin, flag, status.
// - Pin field reads 10 after clearing write.
// - Power-down register resets to 0x70.
// - Power-down bit seven shuts everything listed.
// - Bits five, four gate reference buffers.
// - Bits three to zero: sensor, alerts, outputs.
// - Configuration register resets to zero.
// - Clear leaves pin as alert indicator.
`timescale 1ns/1ps
`default_nettype none

module mcp_regs (
  input  wire logic        CLK,
  input  wire logic        RESET_N,
  input  wire logic        LINK_CLK,
  input  wire logic        SCL_PIN,
  input  wire logic        SDA_PIN,
  input  wire logic [7:0]  REG_ADDR,
  input  wire logic [15:0] REG_WDATA,
  input  wire logic        REG_WR,
  output logic             REG_WR_READY,
  output logic [15:0]      REG_RDATA,
  input  wire logic        CONV_ACTIVE,
  input  wire logic        CONV_BUSY,
  input  wire logic        ALERT_EVENT,
  output logic             SCL_FILT,
  output logic             SDA_FILT,
  output logic             BUS_ACTIVE,
  output logic             SAMPLE_HOLD,
  output logic             TRIAL_HOLD,
  output logic             CONV_ABORT,
  output logic             AUTOCYCLE_EN,
  output logic [1:0]       DIFF_PAIR,
  output logic [1:0]       PSEUDO_PAIR,
  output logic [3:0]       RANGE_X2,
  output logic             ALERT_BUSY_OUT,
  output logic             ALERT_CLEAR,
  output logic             ADC_REF_PD,
  output logic             DAC_REF_PD,
  output logic             TEMP_SENSE_PD,
  output logic             FIRST_CURRENT_SENSE_ALERT_DIS,
  output logic             SECOND_CURRENT_SENSE_ALERT_DIS,
  output logic             DAC_OUT_HIZ
);

  localparam int GW = $clog2(mcp_pkg::GLITCH_CYC + 1);
  localparam int AW = $clog2(mcp_pkg::ACT_CYC + 1);
  localparam int HW = $clog2(mcp_pkg::ABORT_CYC + 1);

  // Pin level with polarity applied
  function automatic logic pin_level(input logic active, input logic active_high);
    pin_level = active_high ? active : ~active;
  endfunction

  logic [1:0]         link_rst_q;
  logic               link_rst_n;
  mcp_pkg::mcp_wreq_t link_wreq;
  mcp_pkg::mcp_wreq_t core_wreq;
  logic               core_wr;
  mcp_pkg::mcp_regs_t cur_regs;
  mcp_pkg::mcp_regs_t sent_q;
  mcp_pkg::mcp_regs_t mirror_d;
  mcp_pkg::mcp_regs_t mirror_q;
  logic               rb_ready;
  logic               rb_push;
  logic               rb_valid;
  logic [15:0]        cfg_q;
  logic [15:0]        cfg_d;
  logic [7:0]         pd_q;
  logic               clear_q;
  logic               cfg_wr;
  logic               pd_wr;
  logic [1:0]         filt_line;
  logic [1:0]         filt_prev_q;
  logic               line_edge;
  logic [AW-1:0]      act_cnt_q;
  logic               bus_act;
  logic [HW-1:0]      hold_cnt_q;
  logic               samp_hold;
  logic               trial_hold;
  logic               alert_q;
  logic               pin_d;
  logic               pd_all;

  // Link-domain reset: asynchronous assert, synchronous release
  always_ff @(posedge LINK_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      link_rst_q <= 2'b00;
    end else begin
      link_rst_q <= {link_rst_q[0], 1'b1};
    end
  end

  assign link_rst_n = link_rst_q[1];

  // Register writes from the link, one word in flight
  assign link_wreq.addr = REG_ADDR;
  assign link_wreq.data = REG_WDATA;

  mcp_word_sync #(
    .W (24)
  ) u_wr_sync (
    .src_clk   (LINK_CLK),
    .src_rst_n (link_rst_n),
    .src_valid (REG_WR),
    .src_ready (REG_WR_READY),
    .src_data  (link_wreq),
    .dst_clk   (CLK),
    .dst_rst_n (RESET_N),
    .dst_valid (core_wr),
    .dst_data  (core_wreq)
  );

  // Register image returned to the link whenever it changes
  assign cur_regs.cfg = cfg_q;
  assign cur_regs.pd  = pd_q;
  assign rb_push      = rb_ready && (cur_regs != sent_q);

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      sent_q.cfg <= mcp_pkg::CFG_RESET;
      sent_q.pd  <= mcp_pkg::PD_RESET;
    end else if (rb_push) begin
      sent_q <= cur_regs;
    end
  end

  mcp_word_sync #(
    .W (24)
  ) u_rb_sync (
    .src_clk   (CLK),
    .src_rst_n (RESET_N),
    .src_valid (rb_push),
    .src_ready (rb_ready),
    .src_data  (cur_regs),
    .dst_clk   (LINK_CLK),
    .dst_rst_n (link_rst_n),
    .dst_valid (rb_valid),
    .dst_data  (mirror_d)
  );

  // Link-side mirror and read data
  always_ff @(posedge LINK_CLK or negedge link_rst_n) begin
    if (!link_rst_n) begin
      mirror_q.cfg <= mcp_pkg::CFG_RESET;
      mirror_q.pd  <= mcp_pkg::PD_RESET;
    end else if (rb_valid) begin
      mirror_q <= mirror_d;
    end
  end

  always_ff @(posedge LINK_CLK or negedge link_rst_n) begin
    if (!link_rst_n) begin
      REG_RDATA <= 16'h0000;
    end else begin
      case (REG_ADDR)
        mcp_pkg::CFG_ADDR: REG_RDATA <= mirror_q.cfg;
        mcp_pkg::PD_ADDR:  REG_RDATA <= {8'h00, mirror_q.pd};
        default:           REG_RDATA <= 16'h0000;     // Unmapped reads zero
      endcase
    end
  end

  // Write decode in the core domain
  assign cfg_wr = core_wr && (core_wreq.addr == mcp_pkg::CFG_ADDR);
  assign pd_wr  = core_wr && (core_wreq.addr == mcp_pkg::PD_ADDR);

  // Configuration next value: reserved masked, clear code folds to alert
  always_comb begin
    cfg_d = core_wreq.data & mcp_pkg::CFG_WMASK;
    if (cfg_d[mcp_pkg::CFG_PF_LSB +: 2] == mcp_pkg::PF_CLEAR) begin
      cfg_d[mcp_pkg::CFG_PF_LSB +: 2] = mcp_pkg::PF_ALERT;
    end
  end

  // Configuration register
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      cfg_q <= mcp_pkg::CFG_RESET;
    end else if (cfg_wr) begin
      cfg_q <= cfg_d;
    end
  end

  // One-cycle clear on each clearing write
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      clear_q <= 1'b0;
    end else begin
      clear_q <= cfg_wr &&
                 (core_wreq.data[mcp_pkg::CFG_PF_LSB +: 2] == mcp_pkg::PF_CLEAR);
    end
  end

  // Power-down register
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      pd_q <= mcp_pkg::PD_RESET;
    end else if (pd_wr) begin
      pd_q <= core_wreq.data[7:0] & mcp_pkg::PD_WMASK;
    end
  end

  // Serial line synchronisers and glitch filters
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_line
      logic [2:0]    sync_q;
      logic          filt_q;
      logic [GW-1:0] cnt_q;
      logic          agreed;

      assign agreed = (sync_q[1] == sync_q[2]);

      // Three stages; idle bus is high
      always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
          sync_q <= 3'b111;
        end else begin
          sync_q <= {sync_q[1:0], (g == 0) ? SCL_PIN : SDA_PIN};
        end
      end

      // Change accepted only after it has stood the glitch time
      always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
          filt_q <= 1'b1;
          cnt_q  <= '0;
        end else if (cfg_q[mcp_pkg::CFG_FILT_OFF_BIT]) begin
          cnt_q <= '0;
          if (agreed) begin
            filt_q <= sync_q[2];
          end
        end else if (agreed && (sync_q[2] != filt_q)) begin
          if (cnt_q == GW'(mcp_pkg::GLITCH_CYC - 1)) begin
            filt_q <= sync_q[2];
            cnt_q  <= '0;
          end else begin
            cnt_q <= cnt_q + 1'b1;
          end
        end else begin
          cnt_q <= '0;
        end
      end

      assign filt_line[g] = filt_q;
    end
  endgenerate

  // Bus activity: any filtered edge, stretched
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      filt_prev_q <= 2'b11;
    end else begin
      filt_prev_q <= filt_line;
    end
  end

  assign line_edge = |(filt_line ^ filt_prev_q);

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      act_cnt_q <= '0;
    end else if (line_edge) begin
      act_cnt_q <= AW'(mcp_pkg::ACT_CYC);
    end else if (act_cnt_q != '0) begin
      act_cnt_q <= act_cnt_q - 1'b1;
    end
  end

  assign bus_act    = line_edge || (act_cnt_q != '0);
  assign samp_hold  = bus_act && !cfg_q[mcp_pkg::CFG_NO_SDELAY_BIT];
  assign trial_hold = bus_act && !cfg_q[mcp_pkg::CFG_NO_TDELAY_BIT];

  // Hold-off duration during a conversion; abort once past the limit
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      hold_cnt_q <= '0;
      CONV_ABORT <= 1'b0;
    end else if (samp_hold && CONV_ACTIVE) begin
      if (hold_cnt_q != HW'(mcp_pkg::ABORT_CYC)) begin
        hold_cnt_q <= hold_cnt_q + 1'b1;
      end
      CONV_ABORT <= (hold_cnt_q == HW'(mcp_pkg::ABORT_CYC - 1));
    end else begin
      hold_cnt_q <= '0;
      CONV_ABORT <= 1'b0;
    end
  end

  // Sticky alert; a new event beats a simultaneous clear
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      alert_q <= 1'b0;
    end else if (ALERT_EVENT) begin
      alert_q <= 1'b1;
    end else if (clear_q) begin
      alert_q <= 1'b0;
    end
  end

  // Shared pin selection
  always_comb begin
    case (cfg_q[mcp_pkg::CFG_PF_LSB +: 2])
      mcp_pkg::PF_BUSY:  pin_d = pin_level(CONV_BUSY, cfg_q[mcp_pkg::CFG_POL_BIT]);
      mcp_pkg::PF_ALERT: pin_d = pin_level(alert_q, cfg_q[mcp_pkg::CFG_POL_BIT]);
      default:           pin_d = pin_level(1'b0, cfg_q[mcp_pkg::CFG_POL_BIT]);
    endcase
  end

  assign pd_all = pd_q[mcp_pkg::PD_ALL_BIT];

  // Registered control outputs
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      SCL_FILT                       <= 1'b1;
      SDA_FILT                       <= 1'b1;
      BUS_ACTIVE                     <= 1'b0;
      SAMPLE_HOLD                    <= 1'b0;
      TRIAL_HOLD                     <= 1'b0;
      AUTOCYCLE_EN                   <= 1'b0;
      DIFF_PAIR                      <= 2'b00;
      PSEUDO_PAIR                    <= 2'b00;
      RANGE_X2                       <= 4'h0;
      ALERT_BUSY_OUT                 <= 1'b1;     // Inactive, active-low default
      ALERT_CLEAR                    <= 1'b0;
      ADC_REF_PD                     <= 1'b1;
      DAC_REF_PD                     <= 1'b1;
      TEMP_SENSE_PD                  <= 1'b0;
      FIRST_CURRENT_SENSE_ALERT_DIS  <= 1'b0;
      SECOND_CURRENT_SENSE_ALERT_DIS <= 1'b0;
      DAC_OUT_HIZ                    <= 1'b0;
    end else begin
      SCL_FILT       <= filt_line[0];
      SDA_FILT       <= filt_line[1];
      BUS_ACTIVE     <= bus_act;
      SAMPLE_HOLD    <= samp_hold;
      TRIAL_HOLD     <= trial_hold;
      AUTOCYCLE_EN   <= cfg_q[mcp_pkg::CFG_AUTO_BIT];
      DIFF_PAIR      <= {cfg_q[mcp_pkg::CFG_DIFF_HI_BIT], cfg_q[mcp_pkg::CFG_DIFF_LO_BIT]};
      PSEUDO_PAIR    <= {cfg_q[mcp_pkg::CFG_PSEUDO_HI_BIT] & cfg_q[mcp_pkg::CFG_DIFF_HI_BIT],
                         cfg_q[mcp_pkg::CFG_PSEUDO_LO_BIT] & cfg_q[mcp_pkg::CFG_DIFF_LO_BIT]};
      RANGE_X2       <= cfg_q[mcp_pkg::CFG_RANGE_LSB +: mcp_pkg::CFG_RANGE_W];
      ALERT_BUSY_OUT <= pin_d;
      ALERT_CLEAR    <= clear_q;
      ADC_REF_PD     <= pd_all | pd_q[mcp_pkg::PD_ADC_REF_BIT];
      DAC_REF_PD     <= pd_all | pd_q[mcp_pkg::PD_DAC_REF_BIT];
      TEMP_SENSE_PD  <= pd_all | pd_q[mcp_pkg::PD_TEMP_BIT];
      FIRST_CURRENT_SENSE_ALERT_DIS  <= pd_all | pd_q[mcp_pkg::PD_CS1_BIT];
      SECOND_CURRENT_SENSE_ALERT_DIS <= pd_all | pd_q[mcp_pkg::PD_CS2_BIT];
      DAC_OUT_HIZ    <= pd_all | pd_q[mcp_pkg::PD_HIZ_BIT];
    end
  end

endmodule

`default_nettype wire

/* core/mcp_word_sync.sv */
`timescale 1ns/1ps
`default_nettype none

module mcp_word_sync #(
  parameter int W = 24
) (
  input  wire logic         src_clk,
  input  wire logic         src_rst_n,
  input  wire logic         src_valid,
  output logic              src_ready,
  input  wire logic [W-1:0] src_data,
  input  wire logic         dst_clk,
  input  wire logic         dst_rst_n,
  output logic              dst_valid,
  output logic [W-1:0]      dst_data
);

  logic         req_q;
  logic [W-1:0] data_q;
  logic [2:0]   ack_s_q;
  logic         ack_seen_q;
  logic [2:0]   req_s_q;
  logic         req_seen_q;
  logic         req_event;

  // Source side: one word in flight until acknowledged
  assign src_ready = (req_q == ack_seen_q);

  always_ff @(posedge src_clk or negedge src_rst_n) begin
    if (!src_rst_n) begin
      req_q  <= 1'b0;
      data_q <= '0;
    end else if (src_valid && src_ready) begin
      req_q  <= ~req_q;
      data_q <= src_data;
    end
  end

  // Acknowledge toggle back into source domain
  always_ff @(posedge src_clk or negedge src_rst_n) begin
    if (!src_rst_n) begin
      ack_s_q    <= 3'b000;
      ack_seen_q <= 1'b0;
    end else begin
      ack_s_q <= {ack_s_q[1:0], req_seen_q};
      if (ack_s_q[1] == ack_s_q[2]) begin
        ack_seen_q <= ack_s_q[2];
      end
    end
  end

  // Destination side: toggle counts once stages two and three agree
  assign req_event = (req_s_q[1] == req_s_q[2]) && (req_s_q[2] != req_seen_q);

  always_ff @(posedge dst_clk or negedge dst_rst_n) begin
    if (!dst_rst_n) begin
      req_s_q    <= 3'b000;
      req_seen_q <= 1'b0;
      dst_valid  <= 1'b0;
      dst_data   <= '0;
    end else begin
      req_s_q   <= {req_s_q[1:0], req_q};
      dst_valid <= req_event;
      if (req_event) begin
        req_seen_q <= req_s_q[2];
        dst_data   <= data_q;     // Held stable by source while in flight
      end
    end
  end

endmodule

`default_nettype wire

/* dv/mcp_host_model.sv */
`timescale 1ns/1ps
`default_nettype none

module mcp_host_model (
  input  wire logic        link_clk,
  output logic [7:0]       reg_addr,
  output logic [15:0]      reg_wdata,
  output logic             reg_wr,
  input  wire logic        reg_wr_ready,
  input  wire logic [15:0] reg_rdata
);
  // Idle request lines
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
  end

  // One write in flight; data released to its inverse once taken
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    for (int n = 0; n < 64 && reg_wr_ready !== 1'b1; n++) @(posedge link_clk);
    @(posedge link_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge link_clk);
    reg_wr <= 1'b0;
    reg_wdata <= ~d;
    repeat (2) @(posedge link_clk);
    for (int n = 0; n < 64 && reg_wr_ready !== 1'b1; n++) @(posedge link_clk);
    repeat (10) @(posedge link_clk);
  endtask

  // Address then two cycles for the registered read word
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge link_clk);
    reg_addr <= a;
    repeat (2) @(posedge link_clk);
    d = reg_rdata;
  endtask
endmodule

`default_nettype wire

/* dv/mcp_regs_sva.sv */
`timescale 1ns/1ps
`default_nettype none

module mcp_regs_sva (
  input wire logic       CLK,
  input wire logic       RESET_N,
  input wire logic       SCL_PIN,
  input wire logic       REG_WR_READY,
  input wire logic       CONV_ACTIVE,
  input wire logic       SCL_FILT,
  input wire logic       SDA_FILT,
  input wire logic       BUS_ACTIVE,
  input wire logic       SAMPLE_HOLD,
  input wire logic       TRIAL_HOLD,
  input wire logic       CONV_ABORT,
  input wire logic       AUTOCYCLE_EN,
  input wire logic [1:0] DIFF_PAIR,
  input wire logic [1:0] PSEUDO_PAIR,
  input wire logic [3:0] RANGE_X2,
  input wire logic       ALERT_CLEAR
);
  logic       scl_q;
  logic       sda_q;
  logic       seen_q;
  logic [8:0] hold_q;
  logic       hold_w;
  logic       edge_w;

  default clocking @(posedge CLK); endclocking
  default disable iff (!RESET_N);

  // Filtered edge detect and hold-off run length
  assign edge_w = (SCL_FILT != scl_q) || (SDA_FILT != sda_q);
  assign hold_w = SAMPLE_HOLD && CONV_ACTIVE;
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      hold_q <= 9'h000;
      seen_q <= 1'b0;
    end else begin
      scl_q <= SCL_FILT;
      sda_q <= SDA_FILT;
      hold_q <= hold_w ? hold_q + {8'h00, hold_q != 9'h1ff} : 9'h000;
      seen_q <= hold_w && (seen_q || CONV_ABORT);
    end
  end

  property p_pair; (PSEUDO_PAIR & ~DIFF_PAIR) == 2'b00; endproperty
  a_pair: assert property (p_pair) else $error("pseudo pair alone");
  property p_quiet; !BUS_ACTIVE ##1 !BUS_ACTIVE |-> !SAMPLE_HOLD && !TRIAL_HOLD; endproperty
  a_quiet: assert property (p_quiet) else $error("hold without activity");
  property p_stretch; edge_w |=> BUS_ACTIVE [*8]; endproperty
  a_stretch: assert property (p_stretch) else $error("activity not held");
  property p_abort_one; CONV_ABORT |=> !CONV_ABORT; endproperty
  a_abort_one: assert property (p_abort_one) else $error("abort too long");
  property p_abort_late; CONV_ABORT |-> hold_q >= 9'h0be; endproperty
  a_abort_late: assert property (p_abort_late) else $error("abort too early");
  property p_abort_due; hold_q == 9'h0dc |-> seen_q; endproperty
  a_abort_due: assert property (p_abort_due) else $error("abort missing");
  property p_clear; ALERT_CLEAR |-> !REG_WR_READY ##1 !ALERT_CLEAR; endproperty
  a_clear: assert property (p_clear) else $error("stray clear");
  property p_cfg; $changed({AUTOCYCLE_EN, DIFF_PAIR, RANGE_X2}) |-> !REG_WR_READY; endproperty
  a_cfg: assert property (p_cfg) else $error("mode moved without write");
  // Pin to filtered output: three sync stages, filter and output flop
  property p_filt; $changed(SCL_FILT) |-> SCL_FILT == $past(SCL_PIN, 5); endproperty
  a_filt: assert property (p_filt) else $error("filter moved against pin");
endmodule

bind mcp_regs mcp_regs_sva mcp_regs_sva_inst (
  .CLK(CLK), .RESET_N(RESET_N), .SCL_PIN(SCL_PIN), .REG_WR_READY(REG_WR_READY),
  .CONV_ACTIVE(CONV_ACTIVE), .SCL_FILT(SCL_FILT), .SDA_FILT(SDA_FILT),
  .BUS_ACTIVE(BUS_ACTIVE), .SAMPLE_HOLD(SAMPLE_HOLD), .TRIAL_HOLD(TRIAL_HOLD),
  .CONV_ABORT(CONV_ABORT), .AUTOCYCLE_EN(AUTOCYCLE_EN), .DIFF_PAIR(DIFF_PAIR),
  .PSEUDO_PAIR(PSEUDO_PAIR), .RANGE_X2(RANGE_X2), .ALERT_CLEAR(ALERT_CLEAR)
);

`default_nettype wire

/* dv/mcp_regs_tb.sv */
`timescale 1ns/1ps
`default_nettype none

module mcp_regs_tb;
  localparam logic [15:0] PF_CFG [6] = '{16'h0000, 16'h0001, 16'h0003, 16'h0003, 16'h0002,
                                         16'h0002};
  localparam logic [5:0]  PF_BSY = 6'b010111;
  localparam logic [5:0]  PF_OUT = 6'b100101;
  logic        clk = 1'b0;
  logic        lclk = 1'b0;
  logic        rst_n = 1'b0;
  logic        scl = 1'b1;
  logic        sda = 1'b1;
  logic        cact = 1'b0;
  logic        cbusy = 1'b0;
  logic        aev = 1'b0;
  logic        act_seen = 1'b0;
  logic        ready, wr, sf, df, act, sh, th, abrt, auto_en, pin, clr;
  logic [7:0]  addr;
  logic [15:0] wdata, rdata, rv, d;
  logic [1:0]  diff, pseu;
  logic [3:0]  rng;
  logic [5:0]  pdo;
  logic [15:0] exp_q[$];
  logic [15:0] seen_q[$];
  int          n_mismatch = 0;
  int          tests_run = 0;
  int          aborts = 0;
  int          clears = 0;
  int          nclr = 0;

  // Core clock and unrelated link clock
  always #2.5 clk = ~clk;
  always #32 lclk = ~lclk;

  mcp_regs mcp_regs_inst (
    .CLK(clk), .RESET_N(rst_n), .LINK_CLK(lclk), .SCL_PIN(scl), .SDA_PIN(sda),
    .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr), .REG_WR_READY(ready),
    .REG_RDATA(rdata), .CONV_ACTIVE(cact), .CONV_BUSY(cbusy), .ALERT_EVENT(aev),
    .SCL_FILT(sf), .SDA_FILT(df), .BUS_ACTIVE(act), .SAMPLE_HOLD(sh), .TRIAL_HOLD(th),
    .CONV_ABORT(abrt), .AUTOCYCLE_EN(auto_en), .DIFF_PAIR(diff), .PSEUDO_PAIR(pseu),
    .RANGE_X2(rng), .ALERT_BUSY_OUT(pin), .ALERT_CLEAR(clr), .ADC_REF_PD(pdo[5]),
    .DAC_REF_PD(pdo[4]), .TEMP_SENSE_PD(pdo[3]), .FIRST_CURRENT_SENSE_ALERT_DIS(pdo[2]),
    .SECOND_CURRENT_SENSE_ALERT_DIS(pdo[1]), .DAC_OUT_HIZ(pdo[0])
  );
  mcp_host_model mcp_host_model_inst (
    .link_clk(lclk), .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr),
    .reg_wr_ready(ready), .reg_rdata(rdata)
  );

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic note(input logic [15:0] seen, input logic [15:0] exp);
    seen_q.push_back(seen);
    exp_q.push_back(exp);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic pins(input logic c, input logic s, input int n);
    @(posedge clk);
    scl <= c;
    sda <= s;
    tick(n - 1);
  endtask
  task automatic wcfg(input logic [15:0] v);
    mcp_host_model_inst.wr(mcp_pkg::CFG_ADDR, v);
  endtask
  task automatic pulse();
    @(posedge clk);
    aev <= 1'b1;
    @(posedge clk);
    aev <= 1'b0;
    tick(3);
  endtask
  task automatic wrap_up();
    if (n_mismatch == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // Event counters and the note checker
  always @(posedge clk) begin
    aborts <= aborts + int'(abrt === 1'b1);
    clears <= clears + int'(clr === 1'b1);
    if (act === 1'b1) act_seen <= 1'b1;
    while (seen_q.size() > 0) check(seen_q.pop_front(), exp_q.pop_front());
  end

  // Main sequence
  initial begin
    void'($urandom(30108));
    repeat (2) @(posedge lclk);
    @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge lclk);
    tick(1);
    note({10'h000, pdo}, 16'h0030);
    note({7'h00, auto_en, pseu, diff, rng}, 16'h0000);
    note({9'h000, sf, df, act, sh, th, abrt, clr}, 16'h0060);
    mcp_host_model_inst.rd(mcp_pkg::CFG_ADDR, rv);
    note(rv, 16'h0000);
    mcp_host_model_inst.rd(mcp_pkg::PD_ADDR, rv);
    note(rv, 16'h0070);
    // Power-down bits one at a time, then all
    for (int i = 0; i < 9; i++) begin
      d = (i == 8) ? 16'h00ff : 16'h0001 << i;
      d[15:8] = 8'($urandom);
      mcp_host_model_inst.wr(mcp_pkg::PD_ADDR, d);
      mcp_host_model_inst.rd(mcp_pkg::PD_ADDR, rv);
      note(rv, {8'h00, d[7:0] & 8'hbf});
      note({10'h000, pdo}, {10'h000, {6{d[7]}} | d[5:0]});
    end
    // Random configuration words, the first one clearing
    for (int i = 0; i < 6; i++) begin
      d = 16'($urandom);
      if (i == 0) d[2:1] = 2'b11;
      nclr += int'(d[2:1] == 2'b11);
      wcfg(d);
      mcp_host_model_inst.rd(mcp_pkg::CFG_ADDR, rv);
      if (d[2:1] == 2'b11) d[2:1] = 2'b10;
      note(rv, d & 16'h7fff);
      note({7'h00, auto_en, pseu, diff, rng},
           {7'h00, d[12], d[11] & d[9], d[10] & d[8], d[9:8], d[7:4]});
    end
    // Unmapped place
    mcp_host_model_inst.wr(8'h33, 16'hffff);
    mcp_host_model_inst.rd(8'h33, rv);
    note(rv, 16'h0000);
    mcp_host_model_inst.rd(mcp_pkg::CFG_ADDR, rv);
    note(rv, d & 16'h7fff);
    // Shared pin function and polarity
    for (int i = 0; i < 6; i++) begin
      wcfg(PF_CFG[i]);
      @(posedge clk);
      cbusy <= PF_BSY[i];
      tick(3);
      note({15'h0000, pin}, {15'h0000, PF_OUT[i]});
    end
    @(posedge clk);
    cbusy <= 1'b0;
    wcfg(16'h0005);
    note({15'h0000, pin}, 16'h0000);
    pulse();
    note({15'h0000, pin}, 16'h0001);
    wcfg(16'h0007);
    nclr++;
    note({15'h0000, pin}, 16'h0000);
    mcp_host_model_inst.rd(mcp_pkg::CFG_ADDR, rv);
    note(rv, 16'h0005);
    pulse();
    note({15'h0000, pin}, 16'h0001);
    // Glitch, activity, hold-off and abort; writes only while idle
    wcfg(16'h0000);
    act_seen = 1'b0;
    pins(1'b1, 1'b0, 5);
    pins(1'b1, 1'b1, 20);
    note({15'h0000, act_seen}, 16'h0000);
    pins(1'b1, 1'b0, 20);
    note({12'h000, df, act, sh, th}, 16'h0007);
    @(posedge clk);
    cact <= 1'b1;
    for (int k = 0; k < 10; k++) pins(k[0], k[0], 30);
    @(posedge clk);
    cact <= 1'b0;
    tick(100);
    note(16'(aborts), 16'h0001);
    wcfg(16'h4000);
    cact <= 1'b1;
    for (int k = 0; k < 4; k++) pins(k[0], k[0], 30);
    note({14'h0000, sh, th}, 16'h0001);
    @(posedge clk);
    cact <= 1'b0;
    tick(100);
    note(16'(aborts), 16'h0001);
    // Filter bypass lets a short glitch through
    wcfg(16'h0008);
    act_seen = 1'b0;
    pins(1'b0, 1'b1, 5);
    pins(1'b1, 1'b1, 10);
    note({15'h0000, act_seen}, 16'h0001);
    note(16'(clears), 16'(nclr));
    tick(2);
    wrap_up();
  end

  // Hang guard
  initial begin
    #200000;
    n_mismatch++;
    wrap_up();
  end
endmodule

`default_nettype wire

/* inc/mcp_pkg.sv */
`default_nettype none

package mcp_pkg;

  // Register indices on the serial register port
  localparam logic [7:0]  CFG_ADDR      = 8'h09;
  localparam logic [7:0]  PD_ADDR       = 8'h0a;

  // Reset values
  localparam logic [15:0] CFG_RESET     = 16'h0000;
  localparam logic [7:0]  PD_RESET      = 8'h70;

  // Writable bits; writes clear reserved bits, but PD_RESET sets pd bit 6
  localparam logic [15:0] CFG_WMASK     = 16'h7fff;
  localparam logic [7:0]  PD_WMASK      = 8'hbf;

  // Configuration field positions
  localparam int CFG_NO_SDELAY_BIT = 14;
  localparam int CFG_NO_TDELAY_BIT = 13;
  localparam int CFG_AUTO_BIT      = 12;
  localparam int CFG_PSEUDO_HI_BIT = 11;
  localparam int CFG_PSEUDO_LO_BIT = 10;
  localparam int CFG_DIFF_HI_BIT   = 9;
  localparam int CFG_DIFF_LO_BIT   = 8;
  localparam int CFG_RANGE_LSB     = 4;
  localparam int CFG_RANGE_W       = 4;
  localparam int CFG_FILT_OFF_BIT  = 3;
  localparam int CFG_PF_LSB        = 1;
  localparam int CFG_POL_BIT       = 0;

  // Power-down field positions
  localparam int PD_ALL_BIT        = 7;
  localparam int PD_ADC_REF_BIT    = 5;
  localparam int PD_DAC_REF_BIT    = 4;
  localparam int PD_TEMP_BIT       = 3;
  localparam int PD_CS1_BIT        = 2;
  localparam int PD_CS2_BIT        = 1;
  localparam int PD_HIZ_BIT        = 0;

  // Timing, in ns, and derived cycle counts
  localparam int CLK_PERIOD_NS     = 5;
  localparam int GLITCH_NS         = 50;
  localparam int GLITCH_CYC        = (GLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ABORT_NS          = 1000;
  localparam int ABORT_CYC         = ABORT_NS / CLK_PERIOD_NS;
  localparam int ACT_NS            = 300;
  localparam int ACT_CYC           = (ACT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Shared output pin function
  typedef enum logic [1:0] {
    PF_NONE  = 2'b00,
    PF_BUSY  = 2'b01,
    PF_ALERT = 2'b10,
    PF_CLEAR = 2'b11
  } mcp_pinfunc_t;

  // Register write request crossing from the link
  typedef struct packed {
    logic [7:0]  addr;
    logic [15:0] data;
  } mcp_wreq_t;

  // Register image returned to the link
  typedef struct packed {
    logic [15:0] cfg;
    logic [7:0]  pd;
  } mcp_regs_t;

endpackage

`default_nettype wire
